/* sim/nco_sync_amp_frequency_word_asserts.sv */
// assertion checker for the nco sync register bank
`timescale 1ns/1ps
module nco_sync_amp_frequency_word_asserts #(
  parameter RUN = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire sync_event_o,
  input wire [3:0] accum_clear_o,
  input wire fast_reconfig_enable_o,
  input wire [63:0] active_freq0_o,
  input wire [15:0] active_amp_ch0_o,
  input wire [15:0] active_amp_ch1_o,
  input wire [15:0] active_amp_ch2_o,
  input wire [15:0] active_amp_ch3_o
);
  // ----------------------------------------
  // shadow of written control bits
  // ----------------------------------------
  wire wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  wire [9:0] idx = wb_adr_i[11:2];
  reg trig_reg, ss_reg, fr_reg;
  reg [1:0] src_reg;
  reg [8:0] gap_reg, age_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_reg <= 1'b0;
      ss_reg <= 1'b0;
      fr_reg <= 1'b0;
      src_reg <= 2'h0;
      gap_reg <= 9'h000;
      age_reg <= 9'h000;
    end else begin
      if (wr && idx == 10'h304) trig_reg <= wb_dat_i[0];
      if (wr && idx == 10'h305) ss_reg <= wb_dat_i[0];
      if (wr && idx == 10'h3f0) src_reg <= wb_dat_i[1:0];
      if (wr && idx == 10'h3f0) fr_reg <= wb_dat_i[4];
      // saturate so a long idle run cannot wrap back into range
      gap_reg <= sync_event_o ? 9'h000 : gap_reg + {8'h00, gap_reg != 9'h1ff};
      age_reg <= !ss_reg ? 9'h000 : age_reg + {8'h00, age_reg != 9'h1ff};
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged on next cycle");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside ack");
  a_clear_event: assert property (accum_clear_o != 4'h0 |-> sync_event_o)
    else $error("accumulator clear without sync event");
  a_fr_clear: assert property (
    fast_reconfig_enable_o && $past(fast_reconfig_enable_o) |-> accum_clear_o == 4'h0)
    else $error("accumulator clear during fast reconfiguration");
  a_trig_event: assert property (
    wr && idx == 10'h304 && wb_dat_i[0] && !trig_reg && src_reg == 2'h0 && !fr_reg
    |=> ##1 sync_event_o)
    else $error("immediate trigger gave no event");
  a_frequency_word_hold: assert property ($changed(active_freq0_o) |-> sync_event_o)
    else $error("frequency changed outside sync event");
  a_amp_hold: assert property (
    $changed({active_amp_ch0_o, active_amp_ch1_o, active_amp_ch2_o, active_amp_ch3_o})
    |-> sync_event_o)
    else $error("amplitude changed outside sync event");
  a_self_period: assert property (age_reg >= 9'h12c |-> gap_reg < 9'h100)
    else $error("self sync period exceeded");
  c_clear: cover property (sync_event_o && accum_clear_o != 4'h0);
  c_fr_event: cover property (sync_event_o && fast_reconfig_enable_o);
  c_self: cover property (age_reg >= 9'h12c && sync_event_o);
endmodule

bind nco_sync_amp_frequency_word nco_sync_amp_frequency_word_asserts #(.RUN(RUN)) nco_sync_amp_frequency_word_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .sync_event_o(sync_event_o), .accum_clear_o(accum_clear_o),
  .fast_reconfig_enable_o(fast_reconfig_enable_o), .active_freq0_o(active_freq0_o),
  .active_amp_ch0_o(active_amp_ch0_o), .active_amp_ch1_o(active_amp_ch1_o),
  .active_amp_ch2_o(active_amp_ch2_o), .active_amp_ch3_o(active_amp_ch3_o));

/* sim/nco_sync_amp_frequency_word_bench.sv */
// self-checking bench for the nco sync register bank
`timescale 1ns/1ps
module nco_sync_amp_frequency_word_bench;
  typedef struct packed {logic [11:0] adr; logic [31:0] wd; logic [31:0] rd;} row_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic sysref = 1'b0;
  logic lsb = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [3:0] last_clr = 4'h0;
  wire [31:0] dat_o;
  wire ack_o, ev_o, seed_o, dp_o, fr_o;
  wire [3:0] clr_o;
  wire [63:0] frequency_word_o;
  wire [15:0] amp0, amp1, amp2, amp3;
  integer n_fail = 0, checks = 0, n_ev = 0, k, i;
  logic [11:0] zero_adr [0:7] = '{12'hc10, 12'hc14, 12'hc60, 12'hc68, 12'hc70, 12'hc78,
    12'hc80, 12'hc84};
  row_t rows [0:7] = '{
    '{12'hc0c, 32'h00000005, 32'h00000005}, '{12'hc60, 32'habcd8001, 32'h00008001},
    '{12'hc68, 32'h00007fff, 32'h00007fff}, '{12'hc70, 32'h00001234, 32'h00001234},
    '{12'hc78, 32'h0000fedc, 32'h0000fedc}, '{12'hc80, 32'h89abcdef, 32'h89abcdef},
    '{12'hc84, 32'h01234567, 32'h01234567}, '{12'hc00, 32'hffffffff, 32'h00000000}};
  always #4 clk_i = ~clk_i;
  nco_sync_amp_frequency_word #(.RUN(4)) nco_sync_amp_frequency_word_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
    .sysref_i(sysref), .upconverter_channel_zero_i_lsb_i(lsb), .sync_event_o(ev_o), .accum_clear_o(clr_o),
    .seed_from_ref0_o(seed_o), .datapath_enable_o(dp_o), .fast_reconfig_enable_o(fr_o),
    .active_freq0_o(frequency_word_o), .active_amp_ch0_o(amp0), .active_amp_ch1_o(amp1),
    .active_amp_ch2_o(amp2), .active_amp_ch3_o(amp3));
  always @(posedge clk_i) if (ev_o === 1'b1) begin
    n_ev <= n_ev + 1;
    last_clr <= clr_o;
  end
  task check_val(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // one classic cycle; ack and read data are taken at the rising edge that shows ack
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rdat = dat_o;
    req <= 1'b0;
    we <= 1'b0;
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  task pulse_ref;
    sysref <= 1'b1;
    tick(4);
    sysref <= 1'b0;
    tick(4);
  endtask
  task lsb_run(input integer lo, input integer hi);
    integer j;
    for (j = 0; j < lo + hi; j = j + 1) begin
      @(posedge clk_i);
      lsb <= (j >= lo);
    end
    @(posedge clk_i);
    lsb <= 1'b0;
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail = n_fail + 1;
    wrap_up;
  end
  initial begin
    tick(3);
    rst_i <= 1'b0;
    bus(0, 12'hc0c, 0);
    check_val("mask reset", 64'h0f, rdat);
    for (i = 0; i < 8; i = i + 1) begin
      bus(0, zero_adr[i], 0);
      check_val("reset value", 64'h0, rdat);
    end
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      bus(1, rows[i].adr, rows[i].wd);
      bus(0, rows[i].adr, 0);
      check_val("readback", rows[i].rd, rdat);
    end
    check_val("amp pending", 64'h0, amp0);
    $display("test registers done");
    bus(1, 12'hfc0, 32'h20);
    k = n_ev;
    bus(1, 12'hc10, 1);
    tick(4);
    check_val("immediate event", k + 1, n_ev);
    check_val("clear mask", 64'h5, last_clr);
    check_val("frequency_word applied", 64'h0123456789abcdef, frequency_word_o);
    check_val("amp3 applied", 64'hfedc, amp3);
    bus(0, 12'hc10, 0);
    check_val("trigger readback", 64'h1, rdat);
    bus(1, 12'hc10, 1);
    tick(4);
    check_val("rewrite one", k + 1, n_ev);
    bus(1, 12'hc10, 0);
    bus(1, 12'hfc0, 32'h21);
    k = n_ev;
    bus(1, 12'hc10, 1);
    tick(8);
    check_val("armed wait", k, n_ev);
    pulse_ref;
    pulse_ref;
    tick(4);
    check_val("sysref once", k + 1, n_ev);
    bus(1, 12'hc10, 0);
    bus(1, 12'hfc0, 32'h22);
    bus(1, 12'hc10, 1);
    k = n_ev;
    pulse_ref;
    pulse_ref;
    tick(4);
    check_val("sysref every", k + 2, n_ev);
    bus(1, 12'hc10, 0);
    pulse_ref;
    tick(4);
    check_val("level low", k + 2, n_ev);
    bus(1, 12'hfc0, 32'h23);
    bus(1, 12'hc10, 1);
    k = n_ev;
    lsb_run(5, 3);
    tick(6);
    check_val("short high run", k, n_ev);
    lsb_run(4, 3);
    lsb_run(1, 4);
    tick(6);
    check_val("broken low run", k, n_ev);
    lsb_run(4, 4);
    tick(6);
    check_val("lsb pattern", k + 1, n_ev);
    bus(1, 12'hc10, 0);
    $display("test sources done");
    bus(1, 12'hfc0, 32'h10);
    k = n_ev;
    bus(1, 12'hc10, 1);
    tick(4);
    check_val("fast reconfig trigger", k, n_ev);
    check_val("fast reconfig out", 64'h1, fr_o);
    check_val("datapath off", 64'h0, dp_o);
    bus(1, 12'hc10, 0);
    bus(1, 12'hc0c, 0);
    bus(1, 12'hc80, 32'h00000001);
    bus(1, 12'hc60, 32'h00001111);
    bus(1, 12'hc14, 1);
    tick(4);
    check_val("self sync start", k + 1, n_ev);
    check_val("amp under fast reconfig", 64'h1111, amp0);
    check_val("frequency_word blocked", 64'h0123456789abcdef, frequency_word_o);
    check_val("no clear", 64'h0, last_clr);
    bus(1, 12'hfc0, 32'h60);
    bus(0, 12'hfc0, 0);
    check_val("config readback", 64'h60, rdat);
    tick(300);
    k = n_ev;
    tick(512);
    check_val("self sync period", k + 2, n_ev);
    check_val("frequency_word self sync", 64'h0123456700000001, frequency_word_o);
    check_val("seed on", 64'h1, seed_o);
    check_val("fast reconfig off", 64'h0, fr_o);
    check_val("datapath on", 64'h1, dp_o);
    bus(1, 12'hc14, 0);
    bus(1, 12'hc68, 32'h00002222);
    bus(1, 12'hc84, 32'h00000000);
    tick(300);
    check_val("amp1 held", 64'h7fff, amp1);
    bus(1, 12'hc14, 1);
    tick(4);
    check_val("amp1 together", 64'h2222, amp1);
    check_val("frequency_word together", 64'h1, frequency_word_o);
    bus(1, 12'hfc0, 32'h160);
    tick(3);
    check_val("seed off", 64'h0, seed_o);
    $display("test self sync done");
    rst_i <= 1'b1;
    tick(3);
    rst_i <= 1'b0;
    check_val("frequency_word after reset", 64'h0, frequency_word_o);
    check_val("amp1 after reset", 64'h0, amp1);
    check_val("seed after reset", 64'h0, seed_o);
    bus(0, 12'hc0c, 0);
    check_val("mask after reset", 64'h0f, rdat);
    bus(0, 12'hc14, 0);
    check_val("self sync after reset", 64'h0, rdat);
    $display("test mid-run reset done");
    wrap_up;
  end
endmodule

/* verilog/lsb_pattern_detect.v */
// detector for a low run then a high run on the in-phase sample lsb
`timescale 1ns/1ps
`include "nco_sync_amp_frequency_word_regs.vh"
module lsb_pattern_detect #(
  parameter RUN = `LSB_RUN
) (
  input wire clk_i,
  input wire rst_i,
  input wire enable_i,
  input wire lsb_i,
  output reg fire_o
);

  localparam [2:0] RUN_W = RUN;
  localparam [2:0] RUN_LAST = RUN - 1;

  reg [2:0] low_cnt_reg;
  reg [2:0] high_cnt_reg;

  // ----------------------------------------------------------------------
  // run counters
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i || !enable_i) begin
      low_cnt_reg <= 3'h0;
      high_cnt_reg <= 3'h0;
      fire_o <= 1'b0;
    end else begin
      fire_o <= 1'b0;
      if (!lsb_i) begin
        high_cnt_reg <= 3'h0;
        if (high_cnt_reg != 3'h0) begin
          // a broken high run starts a fresh low run
          low_cnt_reg <= 3'h1;
        end else if (low_cnt_reg != RUN_W) begin
          low_cnt_reg <= low_cnt_reg + 3'h1;
        end
      end else if (low_cnt_reg == RUN_W) begin
        // lows seen long enough: count highs, fire on the last one
        if (high_cnt_reg == RUN_LAST) begin
          fire_o <= 1'b1;
          low_cnt_reg <= 3'h0;
          high_cnt_reg <= 3'h0;
        end else begin
          high_cnt_reg <= high_cnt_reg + 3'h1;
        end
      end else begin
        low_cnt_reg <= 3'h0;
        high_cnt_reg <= 3'h0;
      end
    end
  end

endmodule

/* verilog/nco_sync_amp_frequency_word.v */
// nco sync, amplitude and frequency register bank with wishbone slave
//
// How it works
// - four mask bits clear chosen oscillator accumulators on every sync event.
// - fast reconfiguration blocks mask, software trigger and register frequency word.
// - writing one to the trigger bit while it is zero fires events.
// - trigger bit reads back last value written, never self-clears.
// - trigger acts as edge or level depending on sync source.
// - source 0 immediate, 1 next sysref rise, 2 every sysref rise.
// - source 3 fires after four or more low lsb then four high.
// - self-sync resynchronises all oscillators once every 256 clocks.
// - self-sync bit may change while datapath runs.
// - re-enabling self-sync applies all new values at once everywhere.
// - self-sync with seeding and no phase-continuous seeds all from channel zero.
// - four signed 16-bit amplitude values at every second register index from 0x318.
// - new amplitude and frequency wait pending until next sync event.
// - 64-bit frequency word drives accumulator increment, sign-agnostic.
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "nco_sync_amp_frequency_word_regs.vh"
module nco_sync_amp_frequency_word #(
  parameter RUN = `LSB_RUN
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sysref_i,
  input wire upconverter_channel_zero_i_lsb_i,
  output reg sync_event_o,
  output reg [3:0] accum_clear_o,
  output reg seed_from_ref0_o,
  output reg datapath_enable_o,
  output reg fast_reconfig_enable_o,
  output reg [63:0] active_freq0_o,
  output reg [15:0] active_amp_ch0_o,
  output reg [15:0] active_amp_ch1_o,
  output reg [15:0] active_amp_ch2_o,
  output reg [15:0] active_amp_ch3_o
);

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  reg [7:0] mask_reg;
  reg [7:0] trig_reg;
  reg [7:0] ss_reg;
  reg [15:0] amp_reg [0:3];
  reg [63:0] frequency_word_reg;
  reg [1:0] src_reg;
  reg fast_reconfig_enable_reg;
  reg datapath_enable_reg;
  reg sc_en_reg;
  reg [3:0] cont_reg;

  // ----------------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------------
  reg sysref_meta_reg;
  reg sysref_sync_reg;
  reg sysref_prev_reg;
  reg armed_reg;
  reg ss_prev_reg;
  reg [7:0] ss_cnt_reg;
  reg [7:0] event_cnt_reg;
  reg trig_rise_reg;

  wire bus_req;
  wire bus_wr;
  wire [9:0] idx;
  wire sysref_rise;
  wire pattern_fire;
  wire ss_on;
  wire ss_fire;
  wire soft_fire;
  wire any_fire;
  wire trig_level;
  wire trig_write_rise;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr = bus_req && wb_we_i;
  assign idx = wb_adr_i[11:2];
  assign trig_level = trig_reg[0] && !fast_reconfig_enable_reg;
  assign ss_on = ss_reg[0];

  // zero-to-one write of the trigger bit
  assign trig_write_rise = bus_wr && (idx == `IDX_SOFT_SYNC_TRIGGER) && wb_sel_i[0]
    && wb_dat_i[0] && !trig_reg[0];

  function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer b;
    begin
      merge = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // bus writes
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= {4'h0, `RST_ACCUM_RESET_MASK};
      trig_reg <= 8'h00;
      ss_reg <= 8'h00;
      frequency_word_reg <= `RST_FREQUENCY_WORD;
      src_reg <= `RST_SRC;
      fast_reconfig_enable_reg <= 1'b0;
      datapath_enable_reg <= 1'b0;
      sc_en_reg <= 1'b0;
      cont_reg <= 4'h0;
    end else if (bus_wr) begin
      case (idx)
        `IDX_ACCUM_RESET_MASK: begin
          mask_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : mask_reg;
        end
        `IDX_SOFT_SYNC_TRIGGER: begin
          // plain storage, no self-clear after firing
          trig_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : trig_reg;
        end
        `IDX_SELF_SYNC_CONTROL: begin
          // accepted at any time, datapath running or not
          ss_reg <= wb_sel_i[0] ? wb_dat_i[7:0] : ss_reg;
        end
        `IDX_FREQ0_LO: begin
          frequency_word_reg[31:0] <= merge(frequency_word_reg[31:0], wb_dat_i, wb_sel_i);
        end
        `IDX_FREQ0_HI: begin
          frequency_word_reg[63:32] <= merge(frequency_word_reg[63:32], wb_dat_i, wb_sel_i);
        end
        `IDX_SYNC_CONFIG: begin
          if (wb_sel_i[0]) begin
            src_reg <= wb_dat_i[`CFG_SRC_HI:`CFG_SRC_LO];
            fast_reconfig_enable_reg <= wb_dat_i[`CFG_FAST_RECONFIG_ENABLE];
            datapath_enable_reg <= wb_dat_i[`CFG_DATAPATH_ENABLE];
            sc_en_reg <= wb_dat_i[`CFG_SC_EN];
          end
          if (wb_sel_i[1]) begin
            cont_reg <= wb_dat_i[`CFG_CONT_HI:`CFG_CONT_LO];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // amplitude slots, one per synthesis channel
  // ----------------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : amp_slot
      localparam [9:0] AMP_IDX = `IDX_AMP_CH0 + 2 * ch;
      always @(posedge clk_i) begin
        if (rst_i) begin
          amp_reg[ch] <= `RST_AMP;
        end else if (bus_wr && (idx == AMP_IDX)) begin
          amp_reg[ch] <= {(wb_sel_i[1] ? wb_dat_i[15:8] : amp_reg[ch][15:8]),
            (wb_sel_i[0] ? wb_dat_i[7:0] : amp_reg[ch][7:0])};
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // bus reads and acknowledge
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h00000000;
      if (bus_req && !wb_we_i) begin
        case (idx)
          `IDX_ACCUM_RESET_MASK: wb_dat_o <= {24'h0, mask_reg};
          `IDX_SOFT_SYNC_TRIGGER: wb_dat_o <= {24'h0, trig_reg};
          `IDX_SELF_SYNC_CONTROL: wb_dat_o <= {24'h0, ss_reg};
          `IDX_AMP_CH0: wb_dat_o <= {16'h0, amp_reg[0]};
          `IDX_AMP_CH1: wb_dat_o <= {16'h0, amp_reg[1]};
          `IDX_AMP_CH2: wb_dat_o <= {16'h0, amp_reg[2]};
          `IDX_AMP_CH3: wb_dat_o <= {16'h0, amp_reg[3]};
          `IDX_FREQ0_LO: wb_dat_o <= frequency_word_reg[31:0];
          `IDX_FREQ0_HI: wb_dat_o <= frequency_word_reg[63:32];
          `IDX_SYNC_CONFIG: begin
            wb_dat_o <= {20'h0, cont_reg, 1'b0, sc_en_reg, datapath_enable_reg, fast_reconfig_enable_reg,
              2'h0, src_reg};
          end
          `IDX_SYNC_STATUS: begin
            wb_dat_o <= {16'h0, event_cnt_reg, 5'h0, ss_on, fast_reconfig_enable_reg, armed_reg};
          end
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // sysref synchroniser and edge
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sysref_meta_reg <= 1'b0;
      sysref_sync_reg <= 1'b0;
      sysref_prev_reg <= 1'b0;
    end else begin
      sysref_meta_reg <= sysref_i;
      sysref_sync_reg <= sysref_meta_reg;
      sysref_prev_reg <= sysref_sync_reg;
    end
  end

  assign sysref_rise = sysref_sync_reg && !sysref_prev_reg;

  lsb_pattern_detect #(
    .RUN(RUN)
  ) lsb_pattern_detect_inst (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(trig_level && (src_reg == `SRC_LSB_PATTERN)),
    .lsb_i(upconverter_channel_zero_i_lsb_i),
    .fire_o(pattern_fire)
  );

  // ----------------------------------------------------------------------
  // software trigger by source
  // ----------------------------------------------------------------------
  // the write edge is registered so the event follows the stored bit
  always @(posedge clk_i) begin
    if (rst_i) begin
      trig_rise_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      trig_rise_reg <= trig_write_rise && !fast_reconfig_enable_reg;
      if (src_reg != `SRC_SYSREF_ONCE || fast_reconfig_enable_reg) begin
        armed_reg <= 1'b0;
      end else if (trig_rise_reg) begin
        armed_reg <= 1'b1;
      end else if (sysref_rise) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // edge modes use the write rise, level modes use the stored bit
  assign soft_fire =
    ((src_reg == `SRC_IMMEDIATE) && trig_rise_reg) ||
    ((src_reg == `SRC_SYSREF_ONCE) && armed_reg && sysref_rise) ||
    ((src_reg == `SRC_SYSREF_EVERY) && trig_level && sysref_rise) ||
    ((src_reg == `SRC_LSB_PATTERN) && trig_level && pattern_fire);

  // ----------------------------------------------------------------------
  // self-synchronisation timer
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      ss_prev_reg <= 1'b0;
      ss_cnt_reg <= 8'h00;
    end else begin
      ss_prev_reg <= ss_on;
      if (!ss_on || !ss_prev_reg) begin
        ss_cnt_reg <= 8'h00;
      end else begin
        ss_cnt_reg <= ss_cnt_reg + 8'h01;
      end
    end
  end

  // immediate event on re-enable puts fresh values in together
  assign ss_fire = ss_on && (!ss_prev_reg || ss_cnt_reg == `SS_PERIOD_LAST);
  assign any_fire = soft_fire || ss_fire;

  // ----------------------------------------------------------------------
  // event application
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync_event_o <= 1'b0;
      accum_clear_o <= 4'h0;
      event_cnt_reg <= 8'h00;
      active_freq0_o <= `RST_FREQUENCY_WORD;
      active_amp_ch0_o <= `RST_AMP;
      active_amp_ch1_o <= `RST_AMP;
      active_amp_ch2_o <= `RST_AMP;
      active_amp_ch3_o <= `RST_AMP;
    end else begin
      sync_event_o <= any_fire;
      accum_clear_o <= 4'h0;
      if (any_fire) begin
        event_cnt_reg <= event_cnt_reg + 8'h01;
        if (!fast_reconfig_enable_reg) begin
          accum_clear_o <= mask_reg[3:0];
          active_freq0_o <= frequency_word_reg;
        end
        active_amp_ch0_o <= amp_reg[0];
        active_amp_ch1_o <= amp_reg[1];
        active_amp_ch2_o <= amp_reg[2];
        active_amp_ch3_o <= amp_reg[3];
      end
    end
  end

  // ----------------------------------------------------------------------
  // mode outputs
  // ----------------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      seed_from_ref0_o <= 1'b0;
      datapath_enable_o <= 1'b0;
      fast_reconfig_enable_o <= 1'b0;
    end else begin
      seed_from_ref0_o <= ss_on && sc_en_reg && (cont_reg == 4'h0);
      datapath_enable_o <= datapath_enable_reg;
      fast_reconfig_enable_o <= fast_reconfig_enable_reg;
    end
  end

endmodule

/* verilog/nco_sync_amp_frequency_word_regs.vh */
// register indices, field positions, reset values and timing for the nco sync block
`ifndef NCO_SYNC_AMP_FREQUENCY_WORD_REGS_VH
`define NCO_SYNC_AMP_FREQUENCY_WORD_REGS_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define IDX_ACCUM_RESET_MASK 10'h303
`define IDX_SOFT_SYNC_TRIGGER 10'h304
`define IDX_SELF_SYNC_CONTROL 10'h305
`define IDX_AMP_CH0 10'h318
`define IDX_AMP_CH1 10'h31a
`define IDX_AMP_CH2 10'h31c
`define IDX_AMP_CH3 10'h31e
`define IDX_FREQ0_LO 10'h320
`define IDX_FREQ0_HI 10'h321
`define IDX_SYNC_CONFIG 10'h3f0
`define IDX_SYNC_STATUS 10'h3f1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_ACCUM_RESET_MASK 4'hf
`define RST_AMP 16'h0000
`define RST_FREQUENCY_WORD 64'h0000000000000000
`define RST_SRC 2'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CFG_SRC_LO 0
`define CFG_SRC_HI 1
`define CFG_FAST_RECONFIG_ENABLE 4
`define CFG_DATAPATH_ENABLE 5
`define CFG_SC_EN 6
`define CFG_CONT_LO 8
`define CFG_CONT_HI 11
`define STAT_ARMED 0
`define STAT_FAST_RECONFIG_ENABLE 1
`define STAT_SS_ON 2
`define STAT_CNT_LO 8
`define STAT_CNT_HI 15

// ----------------------------------------------------------------------
// sync source codes and timing
// ----------------------------------------------------------------------
`define SRC_IMMEDIATE 2'h0
`define SRC_SYSREF_ONCE 2'h1
`define SRC_SYSREF_EVERY 2'h2
`define SRC_LSB_PATTERN 2'h3
`define SS_PERIOD_LAST 8'hff
`define LSB_RUN 4

`endif
